// ---- dwc_pkg.sv ----
package dwc_pkg;
    // register indices and byte addresses
    localparam logic [6:0] WDCFG_IDX    = 7'h0b;
    localparam logic [6:0] INCFG_IDX    = 7'h0c;
    localparam logic [6:0] LEVEL_IDX    = 7'h10;
    localparam logic [6:0] OVLF_IDX     = 7'h11;
    localparam logic [6:0] IRQ_ST_IDX   = 7'h12;
    localparam logic [6:0] IRQ_CLR_IDX  = 7'h13;
    localparam logic [6:0] IRQ_EN_IDX   = 7'h14;
    localparam logic [6:0] AW           = 7'h04;
    // reset values
    localparam logic [7:0] WDCFG_RST    = 8'h00;
    localparam logic [7:0] INCFG_RST    = 8'h08;
    localparam logic [3:0] IRQ_EN_RST   = 4'h0;
    // field positions
    localparam int WD_SEL_HI    = 7;
    localparam int WD_SEL_LO    = 6;
    localparam int CUR_SEL_HI   = 5;
    localparam int CUR_SEL_LO   = 4;
    localparam int THR_SEL_HI   = 3;
    localparam int THR_SEL_LO   = 2;
    localparam int SYNC_EN_BIT  = 1;
    localparam int HIGH_UV_BIT  = 0;
    localparam int TYPE2_BIT    = 7;
    localparam int RSVD_BIT     = 6;
    localparam int SMASK_BIT    = 5;
    localparam int LSRC_BIT     = 4;
    localparam int ABOVE_BIT    = 3;
    localparam int STRETCH_BIT  = 2;
    localparam int BLANK_HI     = 1;
    localparam int BLANK_LO     = 0;
    // interrupt status bits
    localparam int EV_SWD       = 0;
    localparam int EV_YWD       = 1;
    localparam int EV_SERR      = 2;
    localparam int EV_OVL       = 3;
    // time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_MS       = 1;
    localparam int WD_A_MS       = 200;
    localparam int WD_B_MS       = 600;
    localparam int WD_C_MS       = 1200;
    localparam int BLANK_A_MS    = 8;
    localparam int BLANK_B_MS    = 50;
    localparam int BLANK_C_MS    = 300;
    localparam int HOLD_MS       = 100;
    localparam logic [10:0] WD_A_T    = 11'(WD_A_MS / TICK_MS);
    localparam logic [10:0] WD_B_T    = 11'(WD_B_MS / TICK_MS);
    localparam logic [10:0] WD_C_T    = 11'(WD_C_MS / TICK_MS);
    localparam logic [8:0]  BLANK_A_T = 9'(BLANK_A_MS / TICK_MS);
    localparam logic [8:0]  BLANK_B_T = 9'(BLANK_B_MS / TICK_MS);
    localparam logic [8:0]  BLANK_C_T = 9'(BLANK_C_MS / TICK_MS);
    localparam logic [6:0]  HOLD_T    = 7'(HOLD_MS / TICK_MS);
endpackage

// ---- dwc_top.sv ----
`timescale 1ns/1ps
module dwc_top #(
    parameter int unsigned TICK_CYCLES_P = dwc_pkg::TICK_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [6:0] address_i,
    input  wire logic       read_i,
    input  wire logic       write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0] byteenable_i,
    output logic [31:0]     readdata_o,
    output logic            waitrequest_o,
    input  wire logic       serial_access_i,
    input  wire logic       sync_strobe_pin_i,
    input  wire logic       supply_uv_lockout_flag_i,
    input  wire logic       supply_warn_i,
    input  wire logic       supply_low_i,
    input  wire logic       main_above_norm_i,
    input  wire logic       main_above_high_i,
    input  wire logic [3:0] chan_below_norm_i,
    input  wire logic [3:0] chan_below_high_i,
    input  wire logic [3:0] channel_io_pin_i,
    input  wire logic [3:0] above_supply_fault_i,
    input  wire logic [3:0] overload_raw_i,
    output logic            serial_wd_timeout_o,
    output logic            sync_wd_timeout_o,
    output logic [1:0]      offstate_wire_current_sel_o,
    output logic [1:0]      supply_short_threshold_sel_o,
    output logic            high_uv_threshold_sel_o,
    output logic            input_type_two_sel_o,
    output logic            supply_ok_out_b_o,
    output logic [3:0]      channel_auto_on_o,
    output logic [3:0]      gate_off_o,
    output logic [3:0]      channel_thermal_overload_o,
    output logic            supply_error_flag_o,
    output logic            irq_o
);
    import dwc_pkg::*;

    localparam int TW = 17;

    initial begin
        if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > (1 << TW)) begin
            $error("tick period out of range");
        end
    end

    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES_P - 1);

    typedef struct packed {
        logic [7:0]       wdcfg;
        logic [7:0]       incfg;
        logic             ack;
        logic [7:0]       rdata;
        logic [TW-1:0]    tick_cnt;
        logic             tick;
        logic [10:0]      swd_cnt;
        logic [10:0]      ywd_cnt;
        logic             swd_to;
        logic             ywd_to;
        logic             sync_prev;
        logic [3:0][8:0]  blank_cnt;
        logic [3:0][6:0]  hold_cnt;
        logic [3:0]       ovl;
        logic [3:0]       gate_off;
        logic [3:0]       auto_on;
        logic             ok_b;
        logic             serr;
        logic [3:0]       level;
        logic [3:0]       irq_st;
        logic [3:0]       irq_en;
    } dwc_state_s;

    dwc_state_s q;
    dwc_state_s d;

    // watchdog limit for a timeout code
    function automatic logic [10:0] wd_limit(input logic [1:0] sel);
        logic [10:0] r;
        r = WD_B_T;
        if (sel == 2'h1) begin
            r = WD_A_T;
        end else if (sel == 2'h3) begin
            r = WD_C_T;
        end
        return r;
    endfunction

    // overload blanking limit, zero means none
    function automatic logic [8:0] blank_limit(input logic [1:0] sel);
        logic [8:0] r;
        r = 9'h000;
        if (sel == 2'h1) begin
            r = BLANK_A_T;
        end else if (sel == 2'h2) begin
            r = BLANK_B_T;
        end else if (sel == 2'h3) begin
            r = BLANK_C_T;
        end
        return r;
    endfunction

    logic        req;
    logic        wr_go;
    logic [7:0]  rd;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic        swd_en;
    logic        ywd_en;
    logic [10:0] ywd_lim;
    logic [10:0] swd_lim;
    logic [8:0]  blim;
    logic [3:0]  chan_fault;
    logic        main_ok;
    logic        serr_raw;
    logic        qual;

    assign req           = read_i | write_i;
    assign waitrequest_o = req & ~q.ack;
    assign wr_go         = write_i & q.ack & byteenable_i[0];
    assign readdata_o    = {24'h000000, q.rdata};

    always_comb begin
        d        = q;
        rd       = 8'h00;
        ev       = 4'h0;
        clr      = 4'h0;
        qual     = 1'b0;
        blim     = blank_limit(q.incfg[BLANK_HI:BLANK_LO]);
        swd_en   = q.wdcfg[WD_SEL_HI:WD_SEL_LO] != 2'h0;
        swd_lim  = wd_limit(q.wdcfg[WD_SEL_HI:WD_SEL_LO]);
        ywd_en   = q.wdcfg[SYNC_EN_BIT];
        ywd_lim  = swd_en ? swd_lim : WD_B_T;
        // bus slave, one wait state
        d.ack = req & ~q.ack;
        if (req && !q.ack) begin
            if (address_i == 7'(WDCFG_IDX * AW)) begin
                rd = q.wdcfg;
            end else if (address_i == 7'(INCFG_IDX * AW)) begin
                rd = q.incfg;
            end else if (address_i == 7'(LEVEL_IDX * AW)) begin
                rd = {4'h0, q.level};
            end else if (address_i == 7'(OVLF_IDX * AW)) begin
                rd = {4'h0, q.ovl};
            end else if (address_i == 7'(IRQ_ST_IDX * AW)) begin
                rd = {4'h0, q.irq_st};
            end else if (address_i == 7'(IRQ_EN_IDX * AW)) begin
                rd = {4'h0, q.irq_en};
            end
            d.rdata = rd;
        end
        if (wr_go) begin
            if (address_i == 7'(WDCFG_IDX * AW)) begin
                d.wdcfg = writedata_i[7:0];
            end else if (address_i == 7'(INCFG_IDX * AW)) begin
                d.incfg = writedata_i[7:0];
            end else if (address_i == 7'(IRQ_CLR_IDX * AW)) begin
                clr = writedata_i[3:0];
            end else if (address_i == 7'(IRQ_EN_IDX * AW)) begin
                d.irq_en = writedata_i[3:0];
            end
        end
        // millisecond time base
        d.tick = 1'b0;
        if (q.tick_cnt == TICK_LAST) begin
            d.tick_cnt = '0;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + TW'(1);
        end
        // serial watchdog
        if (!swd_en) begin
            d.swd_cnt = 11'h000;
            d.swd_to  = 1'b0;
        end else if (serial_access_i) begin
            d.swd_cnt = 11'h000;
            d.swd_to  = 1'b0;
        end else if (q.tick && !q.swd_to) begin
            if (q.swd_cnt >= swd_lim - 11'h001) begin
                d.swd_to   = 1'b1;
                ev[EV_SWD] = 1'b1;
            end else begin
                d.swd_cnt = q.swd_cnt + 11'h001;
            end
        end
        // sync strobe watchdog
        d.sync_prev = sync_strobe_pin_i;
        if (!ywd_en) begin
            d.ywd_cnt = 11'h000;
            d.ywd_to  = 1'b0;
        end else if (sync_strobe_pin_i && !q.sync_prev) begin
            d.ywd_cnt = 11'h000;
            d.ywd_to  = 1'b0;
        end else if (q.tick && !q.ywd_to) begin
            if (q.ywd_cnt >= ywd_lim - 11'h001) begin
                d.ywd_to   = 1'b1;
                ev[EV_YWD] = 1'b1;
            end else begin
                d.ywd_cnt = q.ywd_cnt + 11'h001;
            end
        end
        // supply monitoring
        chan_fault = q.wdcfg[HIGH_UV_BIT] ? chan_below_high_i
                                          : chan_below_norm_i;
        main_ok    = q.wdcfg[HIGH_UV_BIT] ? main_above_high_i
                                          : main_above_norm_i;
        d.ok_b     = ~main_ok;
        d.auto_on  = main_ok ? ~chan_fault : 4'h0;
        serr_raw   = supply_uv_lockout_flag_i | supply_warn_i | supply_low_i
                   | (q.incfg[LSRC_BIT] & (|chan_fault));
        d.serr     = serr_raw & ~q.incfg[SMASK_BIT];
        if (d.serr && !q.serr) begin
            ev[EV_SERR] = 1'b1;
        end
        d.level = q.incfg[LSRC_BIT] ? chan_fault : channel_io_pin_i;
        d.gate_off = above_supply_fault_i & {4{q.incfg[ABOVE_BIT]}};
        // overload blanking and stretch per channel
        for (int i = 0; i < 4; i++) begin
            if (!overload_raw_i[i]) begin
                d.blank_cnt[i] = 9'h000;
            end else if (q.tick && q.blank_cnt[i] < blim) begin
                d.blank_cnt[i] = q.blank_cnt[i] + 9'h001;
            end
            qual = overload_raw_i[i] && q.blank_cnt[i] >= blim;
            if (qual) begin
                d.ovl[i]      = 1'b1;
                d.hold_cnt[i] = 7'h00;
                if (!q.ovl[i]) begin
                    ev[EV_OVL] = 1'b1;
                end
            end else if (q.ovl[i]) begin
                if (!q.incfg[STRETCH_BIT]) begin
                    d.ovl[i] = 1'b0;
                end else if (q.hold_cnt[i] >= HOLD_T) begin
                    d.ovl[i] = 1'b0;
                end else if (q.tick) begin
                    d.hold_cnt[i] = q.hold_cnt[i] + 7'h01;
                end
            end
        end
        // sticky status, set beats clear
        d.irq_st = (q.irq_st & ~clr) | ev;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q        <= '0;
            q.wdcfg  <= WDCFG_RST;
            q.incfg  <= INCFG_RST;
            q.ok_b   <= 1'b1;
            q.irq_en <= IRQ_EN_RST;
        end else begin
            q <= d;
        end
    end

    assign serial_wd_timeout_o          = q.swd_to;
    assign sync_wd_timeout_o            = q.ywd_to;
    assign offstate_wire_current_sel_o  = q.wdcfg[CUR_SEL_HI:CUR_SEL_LO];
    assign supply_short_threshold_sel_o = q.wdcfg[THR_SEL_HI:THR_SEL_LO];
    assign high_uv_threshold_sel_o      = q.wdcfg[HIGH_UV_BIT];
    assign input_type_two_sel_o         = q.incfg[TYPE2_BIT];
    assign supply_ok_out_b_o            = q.ok_b;
    assign channel_auto_on_o            = q.auto_on;
    assign gate_off_o                   = q.gate_off;
    assign channel_thermal_overload_o   = q.ovl;
    assign supply_error_flag_o          = q.serr;
    assign irq_o                        = |(q.irq_st & q.irq_en);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_wd_disable: assert property (
        q.wdcfg[7:6] == 2'h0 |=> !serial_wd_timeout_o
    ) else $error("serial watchdog active while disabled");

    chk_wd_limit: assert property (
        $rose(serial_wd_timeout_o) |->
            $past(q.swd_cnt) == wd_limit($past(q.wdcfg[7:6])) - 11'h001
    ) else $error("serial watchdog expired at wrong count");

    chk_sync_fixed: assert property (
        $rose(sync_wd_timeout_o) && $past(q.wdcfg[7:6]) == 2'h0 |->
            $past(q.ywd_cnt) == WD_B_T - 11'h001
    ) else $error("sync watchdog not at fixed timeout");

    chk_sync_off: assert property (
        !q.wdcfg[1] |=> !sync_wd_timeout_o
    ) else $error("sync watchdog active while disabled");

    chk_supply_ok: assert property (
        (q.wdcfg[0] ? main_above_high_i : main_above_norm_i)
            |=> !supply_ok_out_b_o
    ) else $error("supply ok not asserted");

    chk_serr_mask: assert property (
        q.incfg[5] |=> !supply_error_flag_o
    ) else $error("supply error not masked");

    chk_level_src: assert property (
        !q.incfg[4] |=> q.level == $past(channel_io_pin_i)
    ) else $error("level register shows wrong source");

    chk_chan_excl: assert property (
        !q.incfg[4] && !q.incfg[5] && !supply_uv_lockout_flag_i
            && !supply_warn_i && !supply_low_i |=> !supply_error_flag_o
    ) else $error("channel fault fed supply error");

    chk_gate_off: assert property (
        q.incfg[3] && above_supply_fault_i[0] |=> gate_off_o[0]
    ) else $error("gate not turned off");

    chk_ovl_hold: assert property (
        $fell(q.ovl[3]) && $past(q.incfg[2]) |->
            $past(q.hold_cnt[3]) >= HOLD_T
    ) else $error("overload released before hold time");

    chk_blank_off: assert property (
        q.incfg[1:0] == 2'h0 && overload_raw_i[0] |=> q.ovl[0]
    ) else $error("overload blanked while blanking off");

    chk_bus_wait: assert property (
        req && !q.ack |=> !waitrequest_o
    ) else $error("bus answer not in one wait state");

    chk_sync_limit: assert property (
        $rose(sync_wd_timeout_o) && $past(q.wdcfg[7:6]) != 2'h0 |->
            $past(q.ywd_cnt) == wd_limit($past(q.wdcfg[7:6])) - 11'h001
    ) else $error("sync watchdog expired at wrong count");

    chk_wd_kick: assert property (
        serial_access_i |=> !serial_wd_timeout_o
    ) else $error("serial watchdog not restarted");

    chk_sync_kick: assert property (
        $rose(sync_strobe_pin_i) |=> !sync_wd_timeout_o
    ) else $error("sync watchdog not restarted");

    chk_level_fault: assert property (
        q.incfg[4] |=> q.level == $past(q.wdcfg[0] ? chan_below_high_i
                                                   : chan_below_norm_i)
    ) else $error("level register misses channel faults");

    chk_gate_on: assert property (
        !q.incfg[3] |=> gate_off_o == 4'h0
    ) else $error("gate turned off while protection disabled");

    chk_auto_on: assert property (
        (q.wdcfg[0] ? main_above_high_i : main_above_norm_i)
            |=> channel_auto_on_o
                == ~$past(q.wdcfg[0] ? chan_below_high_i : chan_below_norm_i)
    ) else $error("channels not switched on");

    chk_serr_set: assert property (
        !q.incfg[5] && (supply_uv_lockout_flag_i || supply_warn_i
            || supply_low_i) |=> supply_error_flag_o
    ) else $error("supply fault did not raise supply error");

    chk_blank_hold: assert property (
        q.incfg[1:0] != 2'h0 && overload_raw_i[1] && !q.ovl[1]
            && q.blank_cnt[1] == 9'h000 |=> !q.ovl[1]
    ) else $error("overload reported inside blanking time");

    chk_stretch_off: assert property (
        !q.incfg[2] && !overload_raw_i[0] |=> !q.ovl[0]
    ) else $error("overload held while stretch disabled");
endmodule

// ---- dwc_host.sv ----
`timescale 1ns/1ps
module dwc_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i,
    output logic [6:0]       address_o,
    output logic             read_o,
    output logic             write_o,
    output logic [31:0]      writedata_o,
    output logic [3:0]       byteenable_o
);
    import dwc_pkg::*;
    initial begin
        {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
    end
    // one avalon transfer, held until waitrequest low
    task automatic xfer(input logic w, input logic [6:0] a,
                        input logic [7:0] d, input logic [3:0] be,
                        output logic [31:0] q, output logic ok);
        int n;
        logic [7:0] v;
        v = d;
        if (w && a == 7'(INCFG_IDX << 2)) begin
            v[RSVD_BIT] = 1'b0;
        end
        @(posedge clk_i);
        address_o <= a;
        read_o <= !w;
        write_o <= w;
        writedata_o <= {24'h0, v};
        byteenable_o <= be;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 40);
        ok = waitrequest_i === 1'b0;
        q = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule

// ---- diag_watchdog_config_tb.sv ----
`timescale 1ns/1ps
module diag_watchdog_config_tb;
    import dwc_pkg::*;
    localparam int TK = 10;
    localparam logic [6:0] WA = 7'(WDCFG_IDX << 2);
    localparam logic [6:0] IA = 7'(INCFG_IDX << 2);
    localparam logic [6:0] LA = 7'(LEVEL_IDX << 2);
    localparam logic [6:0] OA = 7'(OVLF_IDX << 2);
    localparam logic [6:0] SA = 7'(IRQ_ST_IDX << 2);
    localparam logic [6:0] CA = 7'(IRQ_CLR_IDX << 2);
    localparam logic [6:0] EA = 7'(IRQ_EN_IDX << 2);
    logic        clk_i, rst_b_i, rd_s, wr_s, wq, sa, sp, an, ah, okb, ok;
    logic [6:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  be, bn, bh, io, asf, ovl, flt, auto, gate, tov;
    logic [2:0]  sf;
    logic [1:0]  cur, thr;
    logic        huv, t2, swd, ywd, okb_o, serr, irq;
    logic [7:0]  wd, inc;
    logic [16:0] r1, r2, r3;
    int          num_errors, num_checks, cycles, i, k, c;
    int          wt[4] = '{0, 200, 600, 1200};
    int          bt[4] = '{0, 8, 50, 300};

    dwc_host host (.clk_i(clk_i), .readdata_i(rdat), .waitrequest_i(wq),
        .address_o(adr), .read_o(rd_s), .write_o(wr_s),
        .writedata_o(wdat), .byteenable_o(be));
    dwc_top #(.TICK_CYCLES_P(TK)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .address_i(adr), .read_i(rd_s), .write_i(wr_s),
        .writedata_i(wdat), .byteenable_i(be), .readdata_o(rdat),
        .waitrequest_o(wq), .serial_access_i(sa), .sync_strobe_pin_i(sp),
        .supply_uv_lockout_flag_i(sf[0]), .supply_warn_i(sf[1]),
        .supply_low_i(sf[2]), .main_above_norm_i(an),
        .main_above_high_i(ah), .chan_below_norm_i(bn),
        .chan_below_high_i(bh), .channel_io_pin_i(io),
        .above_supply_fault_i(asf), .overload_raw_i(ovl),
        .serial_wd_timeout_o(swd), .sync_wd_timeout_o(ywd),
        .offstate_wire_current_sel_o(cur),
        .supply_short_threshold_sel_o(thr), .high_uv_threshold_sel_o(huv),
        .input_type_two_sel_o(t2), .supply_ok_out_b_o(okb_o),
        .channel_auto_on_o(auto), .gate_off_o(gate),
        .channel_thermal_overload_o(tov), .supply_error_flag_o(serr),
        .irq_o(irq));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] v);
        for (int j = 0; j < 17; j++) v = {v[15:0], v[16] ^ v[13]};
        return v;
    endfunction
    task automatic wrap_up;
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
                      input logic [3:0] b);
        host.xfer(1'b1, a, d, b, q, ok);
        chk("write answer", 1, ok);
    endtask
    task automatic rd(input logic [6:0] a);
        host.xfer(1'b0, a, 8'h00, 4'h1, q, ok);
        chk("read answer", 1, ok);
    endtask
    task automatic kick;
        @(posedge clk_i);
        sa <= 1'b1;
        sp <= 1'b1;
        @(posedge clk_i);
        sa <= 1'b0;
        sp <= 1'b0;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        {sa, sp, an, ah, bn, bh, io, asf, ovl, sf} = '0;
        rst_b_i = 1'b0;
        r3 = 17'd95638;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(WA);
        chk("watchdog cfg reset", 8'h00, q);
        rd(IA);
        chk("input cfg reset", 8'h08, q);
        for (i = 0; i < 12; i++) begin
            r1 = lfsr(r3);
            r2 = lfsr(r1);
            r3 = lfsr(r2);
            wd = r1[7:0];
            inc = r1[15:8] & 8'hbf;
            wr(WA, r1[7:0], 4'h1);
            wr(IA, r1[15:8], 4'h1);
            @(posedge clk_i);
            {bh, bn, io, asf} <= r2[15:0];
            {ah, an, sf} <= r3[4:0];
            cyc(3);
            flt = wd[0] ? r2[15:12] : r2[11:8];
            okb = !(wd[0] ? r3[4] : r3[3]);
            rd(WA);
            chk("watchdog cfg", wd, q);
            rd(IA);
            chk("input cfg", inc, q);
            chk("pull-up sel", wd[5:4], cur);
            chk("short thr sel", wd[3:2], thr);
            chk("high uv sel", wd[0], huv);
            chk("type two sel", inc[7], t2);
            chk("gate off", r2[3:0] & {4{inc[3]}}, gate);
            chk("supply ok", okb, okb_o);
            chk("auto on", {4{!okb}} & ~flt, auto);
            chk("supply err", !inc[5] && (|r3[2:0] || (inc[4] && |flt)),
                serr);
            rd(LA);
            chk("level", inc[4] ? flt : r2[7:4], q);
        end
        wr(WA, ~wd, 4'h0);
        rd(WA);
        chk("masked write", wd, q);
        rd(7'h7c);
        chk("unmapped read", 0, q);
        wr(WA, 8'h00, 4'h1);
        @(posedge clk_i);
        {sf, bh, bn, an} <= {3'h0, 4'h0, 4'h1, 1'b1};
        wr(IA, 8'h08, 4'h1);
        wr(CA, 8'h0f, 4'h1);
        wr(EA, 8'h04, 4'h1);
        cyc(3);
        chk("serr level src pin", 0, serr);
        chk("irq idle", 0, irq);
        wr(IA, 8'h18, 4'h1);
        cyc(3);
        chk("serr chan fault", 1, serr);
        chk("irq raised", 1, irq);
        rd(SA);
        chk("status serr", 1, q[EV_SERR]);
        rd(EA);
        chk("enable reg", 8'h04, q);
        wr(CA, 8'h04, 4'h1);
        cyc(2);
        chk("irq cleared", 0, irq);
        wr(IA, 8'h38, 4'h1);
        cyc(3);
        chk("serr masked", 0, serr);
        wr(EA, 8'h00, 4'h1);
        wr(IA, 8'h18, 4'h1);
        cyc(3);
        chk("irq disabled", 0, irq);
        rd(SA);
        chk("status re-set", 1, q[EV_SERR]);
        for (c = 1; c < 4; c++) begin
            wr(WA, 8'(c << 6) | 8'h02, 4'h1);
            kick();
            cyc((wt[c] - 2) * TK);
            chk("serial wd early", 0, swd);
            chk("sync wd early", 0, ywd);
            for (k = 0; k < 4 * TK && swd !== 1'b1; k++) cyc(1);
            chk("serial wd expiry", 1, swd);
            cyc(TK);
            chk("sync wd expiry", 1, ywd);
            kick();
            cyc(3);
            chk("serial wd kicked", 0, swd);
        end
        rd(SA);
        chk("status wd", 2'b11, q[1:0]);
        wr(WA, 8'h02, 4'h1);
        kick();
        cyc((wt[2] - 2) * TK);
        chk("sync fixed early", 0, ywd);
        for (k = 0; k < 4 * TK && ywd !== 1'b1; k++) cyc(1);
        chk("sync fixed expiry", 1, ywd);
        chk("serial wd off", 0, swd);
        wr(WA, 8'h00, 4'h1);
        cyc(3);
        chk("sync wd off", 0, ywd);
        wr(IA, 8'h08, 4'h1);
        @(posedge clk_i);
        ovl <= 4'h1;
        cyc(3);
        chk("no blanking", 4'h1, tov);
        rd(OA);
        chk("overload reg", 4'h1, q);
        @(posedge clk_i);
        ovl <= 4'h0;
        for (c = 1; c < 4; c++) begin
            wr(IA, 8'(c) | 8'h08, 4'h1);
            @(posedge clk_i);
            ovl <= 4'h2;
            cyc((bt[c] - 2) * TK);
            chk("blanked", 4'h0, tov);
            for (k = 0; k < 4 * TK && tov !== 4'h2; k++) cyc(1);
            chk("blank expiry", 4'h2, tov);
            @(posedge clk_i);
            ovl <= 4'h0;
            cyc(3);
            chk("no stretch", 4'h0, tov);
        end
        wr(IA, 8'h0d, 4'h1);
        @(posedge clk_i);
        ovl <= 4'h8;
        for (k = 0; k < 12 * TK && tov !== 4'h8; k++) cyc(1);
        @(posedge clk_i);
        ovl <= 4'h0;
        cyc((HOLD_MS - 2) * TK);
        chk("stretch hold", 4'h8, tov);
        for (k = 0; k < 4 * TK && tov !== 4'h0; k++) cyc(1);
        chk("stretch end", 4'h0, tov);
        rd(SA);
        chk("status overload", 1, q[EV_OVL]);
        wrap_up();
    end
endmodule
